// ---- rtl/drxc_map.svh ----
/*
 Slave address, field positions, reset values and fixed figures of the
 dual receiver control block, as macros.
 Assumes it is included by bare name from the design files.
*/
`ifndef DRXC_MAP_SVH
`define DRXC_MAP_SVH

// slave address, seven bits
`define DRXC_SLAVE_ADDR 7'h6c

// control byte field positions
`define DRXC_SLEEP_BIT 7
`define DRXC_RSVD_BIT 6
`define DRXC_CODE2_MSB 5
`define DRXC_CODE2_LSB 3
`define DRXC_CODE1_MSB 2
`define DRXC_CODE1_LSB 0

// read byte nibble positions
`define DRXC_STR1_MSB 7
`define DRXC_STR1_LSB 4
`define DRXC_STR2_MSB 3
`define DRXC_STR2_LSB 0

// reset values
`define DRXC_SLEEP_RST 1'h1
`define DRXC_CODE_RST 3'h0

// channel frequency table in kHz
`define DRXC_FREQ_BASE_KHZ 15'h6973
`define DRXC_FREQ_STEP_KHZ 15'h0032
`define DRXC_FREQ_TOP_CODE 3'h7
`define DRXC_FREQ_TOP_KHZ 15'h6941

// host clock division ratio
`define DRXC_HOST_DIV 2

// bits per byte on the serial bus
`define DRXC_BYTE_BITS 4'h8

`endif

// ---- rtl/drxc_pkg.sv ----
/*
 Types of the dual receiver control block: bus states and the packed
 state record of the top module.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package drxc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_WAIT_STOP
    } drxc_state_t;

    typedef struct packed {
        drxc_state_t st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic scl_q;
        logic sda_q;
        logic sda_oe_n;
        logic sda_out;
        logic push;
        logic sleep;
        logic [2:0] code1;
        logic [2:0] code2;
        logic [14:0] freq1;
        logic [14:0] freq2;
        logic out1;
        logic out2;
    } drxc_top_t;

endpackage

// ---- rtl/drxc_clkdiv.sv ----
/*
 Free running clock divider for the host clock output.
 Assumes one reference clock and a synchronous active low reset.
*/
`timescale 1ns/10ps
`include "drxc_map.svh"

module drxc_clkdiv #(
    parameter int DIV = `DRXC_HOST_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // divided clock
    output logic clk_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic clk_out;
    } drxc_div_t;

    drxc_div_t cur;
    drxc_div_t next_cur;

    generate
        if (DIV < 2 || DIV > 256 || (DIV % 2) != 0) begin : g_bad
            $error("divider must be even and between 2 and 256");
        end
    endgenerate

    // no gating by sleep: the host runs from this clock at all times
    always_comb begin
        next_cur = cur;
        if (cur.cnt == 8'((DIV / 2) - 1)) begin
            next_cur.cnt = 8'h00;
            next_cur.clk_out = ~cur.clk_out;
        end else begin
            next_cur.cnt = cur.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign clk_out = cur.clk_out;

endmodule // drxc_clkdiv

// ---- rtl/drxc_buf2.sv ----
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/10ps

module drxc_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic rd;
        logic wr;
        logic [1:0] used;
    } drxc_buf_t;

    drxc_buf_t cur;
    drxc_buf_t next_cur;
    logic do_push;
    logic do_pop;

    generate
        if (DEPTH != 2 || WIDTH < 1) begin : g_bad
            $error("buffer serves exactly two entries");
        end
    endgenerate

    assign in_ready = (cur.used != 2'h2);
    assign out_valid = (cur.used != 2'h0);
    assign out_data = cur.slot[cur.rd];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb begin
        next_cur = cur;
        if (do_push) begin
            next_cur.slot[cur.wr] = in_data;
            next_cur.wr = ~cur.wr;
        end
        if (do_pop) begin
            next_cur.rd = ~cur.rd;
        end
        if (do_push && !do_pop) begin
            next_cur.used = cur.used + 2'h1;
        end else if (do_pop && !do_push) begin
            next_cur.used = cur.used - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

endmodule // drxc_buf2

// ---- rtl/drxc_top.sv ----
/*
 Control logic of a two-channel receiver: serial bus slave for the
 control byte and the strength byte, channel codes, sleep state,
 host clock divider and the two demodulated data outputs.
 Assumes SCL and SDA already synchronous to CLK and the analog front
 end delivering strength levels and demodulated bits as levels.
*/
`timescale 1ns/10ps
`include "drxc_map.svh"

module drxc_top (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // serial control bus, SDA split into its three signals
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // analog front end status
    input wire logic [3:0] STRENGTH_1,
    input wire logic [3:0] STRENGTH_2,
    input wire logic DEMOD_1,
    input wire logic DEMOD_2,
    // receiver controls
    output logic SLEEP,
    output logic [2:0] CODE_1,
    output logic [2:0] CODE_2,
    output logic [14:0] FREQ_KHZ_1,
    output logic [14:0] FREQ_KHZ_2,
    // data streams
    output logic OUT_1,
    output logic OUT_2,
    // host clock
    output logic HOST_CLK
);

    drxc_pkg::drxc_top_t cur;
    drxc_pkg::drxc_top_t next_cur;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [7:0] buf_out_data;
    logic host_clk;

    // channel code to local oscillator frequency in kHz
    function automatic logic [14:0] code_to_khz(input logic [2:0] code);
        logic [14:0] step;
        step = 15'(code) * `DRXC_FREQ_STEP_KHZ;
        if (code == `DRXC_FREQ_TOP_CODE) begin
            code_to_khz = `DRXC_FREQ_TOP_KHZ;
        end else begin
            code_to_khz = `DRXC_FREQ_BASE_KHZ + step;
        end
    endfunction

    assign scl_rise = SCL && !cur.scl_q;
    assign scl_fall = !SCL && cur.scl_q;
    // start and stop are SDA edges while SCL stays high
    assign start_seen = SCL && cur.scl_q && cur.sda_q && !SDA_IN;
    assign stop_seen = SCL && cur.scl_q && !cur.sda_q && SDA_IN;

    // written bytes are applied only while the bus is idle, so a
    // byte never changes the codes in the middle of a transfer
    assign buf_out_ready = (cur.st == drxc_pkg::ST_IDLE);

    drxc_buf2 #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_buf (
        .clk(CLK),
        .nrst(NRST),
        .in_valid(cur.push),
        .in_ready(buf_in_ready),
        .in_data(cur.shift),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    drxc_clkdiv #(
        .DIV(`DRXC_HOST_DIV)
    ) u_div (
        .clk(CLK),
        .nrst(NRST),
        .clk_out(host_clk)
    );

    always_comb begin
        next_cur = cur;
        next_cur.scl_q = SCL;
        next_cur.sda_q = SDA_IN;
        next_cur.push = 1'b0;
        next_cur.sda_out = 1'b0;

        if (stop_seen) begin
            next_cur.st = drxc_pkg::ST_IDLE;
            next_cur.sda_oe_n = 1'b1;
        end else if (start_seen) begin
            // a repeated start restarts the address phase
            next_cur.st = drxc_pkg::ST_ADDR;
            next_cur.cnt = 4'h0;
            next_cur.sda_oe_n = 1'b1;
        end else begin
            case (cur.st)
                drxc_pkg::ST_IDLE: begin
                    next_cur.sda_oe_n = 1'b1;
                end
                drxc_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        next_cur.shift = {cur.shift[6:0], SDA_IN};
                        next_cur.cnt = cur.cnt + 4'h1;
                    end else if (scl_fall && cur.cnt == `DRXC_BYTE_BITS) begin
                        next_cur.rw = cur.shift[0];
                        if (cur.shift[7:1] == `DRXC_SLAVE_ADDR) begin
                            next_cur.sda_oe_n = 1'b0;
                            next_cur.st = drxc_pkg::ST_ADDR_ACK;
                        end else begin
                            next_cur.st = drxc_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                drxc_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_cur.cnt = 4'h0;
                        if (cur.rw) begin
                            // one coherent snapshot of both levels
                            next_cur.tx[`DRXC_STR1_MSB:`DRXC_STR1_LSB] =
                                STRENGTH_1;
                            next_cur.tx[`DRXC_STR2_MSB:`DRXC_STR2_LSB] =
                                STRENGTH_2;
                            next_cur.sda_oe_n =
                                STRENGTH_1[3];
                            next_cur.st = drxc_pkg::ST_RDATA;
                        end else begin
                            next_cur.sda_oe_n = 1'b1;
                            next_cur.st = drxc_pkg::ST_WDATA;
                        end
                    end
                end
                drxc_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        next_cur.shift = {cur.shift[6:0], SDA_IN};
                        next_cur.cnt = cur.cnt + 4'h1;
                    end else if (scl_fall && cur.cnt == `DRXC_BYTE_BITS) begin
                        // a full buffer refuses the byte with a NACK
                        if (buf_in_ready) begin
                            next_cur.push = 1'b1;
                            next_cur.sda_oe_n = 1'b0;
                            next_cur.st = drxc_pkg::ST_WDATA_ACK;
                        end else begin
                            next_cur.st = drxc_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                drxc_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        // one byte per transfer, later bytes ignored
                        next_cur.sda_oe_n = 1'b1;
                        next_cur.st = drxc_pkg::ST_WAIT_STOP;
                    end
                end
                drxc_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        next_cur.cnt = cur.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cur.cnt == `DRXC_BYTE_BITS) begin
                            next_cur.sda_oe_n = 1'b1;
                            next_cur.st = drxc_pkg::ST_RDATA_ACK;
                        end else begin
                            next_cur.tx = {cur.tx[6:0], 1'b0};
                            next_cur.sda_oe_n = cur.tx[6];
                        end
                    end
                end
                drxc_pkg::ST_RDATA_ACK: begin
                    if (scl_fall) begin
                        next_cur.st = drxc_pkg::ST_WAIT_STOP;
                    end
                end
                drxc_pkg::ST_WAIT_STOP: begin
                    next_cur.sda_oe_n = 1'b1;
                end
                default: begin
                    next_cur.st = drxc_pkg::ST_IDLE;
                    next_cur.sda_oe_n = 1'b1;
                end
            endcase
        end

        // apply a buffered control byte; the reserved bit is ignored
        if (buf_out_valid && buf_out_ready) begin
            next_cur.sleep = buf_out_data[`DRXC_SLEEP_BIT];
            next_cur.code1 =
                buf_out_data[`DRXC_CODE1_MSB:`DRXC_CODE1_LSB];
            next_cur.code2 =
                buf_out_data[`DRXC_CODE2_MSB:`DRXC_CODE2_LSB];
        end
        next_cur.freq1 = code_to_khz(cur.code1);
        next_cur.freq2 = code_to_khz(cur.code2);

        // a sleeping receiver has no data to show
        next_cur.out1 = DEMOD_1 && !cur.sleep;
        next_cur.out2 = DEMOD_2 && !cur.sleep;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cur <= '0;
            cur.st <= drxc_pkg::ST_IDLE;
            cur.scl_q <= 1'b1;
            cur.sda_q <= 1'b1;
            cur.sda_oe_n <= 1'b1;
            cur.sleep <= `DRXC_SLEEP_RST;
            cur.code1 <= `DRXC_CODE_RST;
            cur.code2 <= `DRXC_CODE_RST;
            cur.freq1 <= `DRXC_FREQ_BASE_KHZ;
            cur.freq2 <= `DRXC_FREQ_BASE_KHZ;
        end else begin
            cur <= next_cur;
        end
    end

    assign SDA_OUT = cur.sda_out;
    assign SDA_OE_N = cur.sda_oe_n;
    assign SLEEP = cur.sleep;
    assign CODE_1 = cur.code1;
    assign CODE_2 = cur.code2;
    assign FREQ_KHZ_1 = cur.freq1;
    assign FREQ_KHZ_2 = cur.freq2;
    assign OUT_1 = cur.out1;
    assign OUT_2 = cur.out2;
    assign HOST_CLK = host_clk;

endmodule // drxc_top

// ---- test/drxc_sva.sv ----
/*
 Checker of the dual receiver control block, bound to drxc_top.
 Assumes one clock and the synchronous active low reset of the top.
*/
`timescale 1ns/10ps

module drxc_sva (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // serial bus
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    // receiver side
    input wire logic DEMOD_1,
    input wire logic DEMOD_2,
    input wire logic SLEEP,
    input wire logic [2:0] CODE_1,
    input wire logic [2:0] CODE_2,
    input wire logic [14:0] FREQ_KHZ_1,
    input wire logic [14:0] FREQ_KHZ_2,
    input wire logic OUT_1,
    input wire logic OUT_2,
    input wire logic HOST_CLK
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    // top code wraps below the base channel
    function automatic logic [14:0] fexp(input logic [2:0] c);
        return (c == 3'h7) ? 15'h6941 : 15'h6973 + {12'h000, c} * 15'h0032;
    endfunction

    sequence s_start;
        SCL && $past(SCL) && $fell(SDA_IN);
    endsequence

    // the data line must stay released for eight clocks after a start
    sequence s_quiet;
        SDA_OE_N [*8];
    endsequence

    AST_HOST_CLK: assert property ($past(NRST) |->
        HOST_CLK != $past(HOST_CLK)) else $error("host clock stalled");
    AST_SDA_DRAIN: assert property (SDA_OUT == 1'b0)
        else $error("data line driven high");
    AST_SLEEP_GATE: assert property (SLEEP && $past(SLEEP) |->
        !OUT_1 && !OUT_2) else $error("output active while asleep");
    AST_OUT_FOLLOW: assert property ($past(NRST) && !SLEEP &&
        !$past(SLEEP) |-> OUT_1 == $past(DEMOD_1) &&
        OUT_2 == $past(DEMOD_2)) else $error("output not demod delayed");
    AST_FREQ_1: assert property ($past(NRST) |->
        FREQ_KHZ_1 == fexp($past(CODE_1))) else $error("freq 1 wrong");
    AST_FREQ_2: assert property ($past(NRST) |->
        FREQ_KHZ_2 == fexp($past(CODE_2))) else $error("freq 2 wrong");
    AST_UPDATE_IDLE: assert property ($changed(CODE_1) ||
        $changed(CODE_2) || $changed(SLEEP) |-> SCL && SDA_IN &&
        $past(SCL)) else $error("control changed on busy bus");
    AST_OE_SCL_LOW: assert property ($changed(SDA_OE_N) |->
        !SCL) else $error("data line moved while clock high");
    AST_START_QUIET: assert property (s_start |=> s_quiet)
        else $error("drive during address phase");
endmodule // drxc_sva

bind drxc_top drxc_sva u_sva (.CLK, .NRST, .SCL, .SDA_IN, .SDA_OUT,
    .SDA_OE_N, .DEMOD_1, .DEMOD_2, .SLEEP, .CODE_1, .CODE_2, .FREQ_KHZ_1,
    .FREQ_KHZ_2, .OUT_1, .OUT_2, .HOST_CLK);

// ---- test/drxc_host.sv ----
/*
 Host master model for the serial control bus.
 Assumes the data line has a pull-up and the device only pulls it low.
*/
`timescale 1ns/10ps

module drxc_host (
    // clock
    input wire logic clk,
    // device side of the data line
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // bus lines as seen on the wire
    output logic scl,
    output logic sda
);
    logic sda_m = 1'b1;

    initial scl = 1'b1;
    // pull-up: a released or unknown drive reads high
    assign sda = sda_m && (sda_oe_n !== 1'b0 || sda_out);

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves only while the clock is low
    // bit rate is far above the board limit to keep runs short
    task automatic pulse(input logic b, output logic s);
        sda_m <= b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        @(negedge clk);
        s = sda;
        tick(2);
        scl <= 1'b0;
        tick(4);
    endtask

    // also serves as repeated start
    task automatic start;
        sda_m <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic stop;
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask

    // one byte per transfer, ack[1] addr, ack[0] data
    task automatic xfer(input logic [6:0] adr, input logic rd,
        input logic [7:0] wd, input logic stp, output logic [1:0] ack,
        output logic [7:0] q);
        logic s;
        logic [7:0] ab;
        ab = {adr, rd};
        start();
        for (int i = 7; i >= 0; i--) begin
            pulse(ab[i], s);
        end
        pulse(1'b1, s);
        ack[1] = ~s;
        for (int i = 7; i >= 0; i--) begin
            pulse(rd | wd[i], s);
            q[i] = s;
        end
        // master acks a read byte low
        pulse(~rd, s);
        ack[0] = ~s;
        if (stp) begin
            stop();
        end
    endtask
endmodule // drxc_host

// ---- test/dual_receiver_i2c_control_tb_top.sv ----
/*
 Self-checking bench of the dual receiver control block.
 Assumes drxc_top, the host model and the bound checker compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end end

module dual_receiver_i2c_control_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] str1 = 4'h0;
    logic [3:0] str2 = 4'h0;
    logic dm1 = 1'b0;
    logic dm2 = 1'b0;
    logic scl, sda, sda_out, sda_oe_n, sleep, o1, o2, hclk;
    logic [2:0] c1, c2;
    logic [14:0] f1, f2;
    int fail_count = 0;
    int checked = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    drxc_top dut (.CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .STRENGTH_1(str1),
        .STRENGTH_2(str2), .DEMOD_1(dm1), .DEMOD_2(dm2), .SLEEP(sleep),
        .CODE_1(c1), .CODE_2(c2), .FREQ_KHZ_1(f1), .FREQ_KHZ_2(f2),
        .OUT_1(o1), .OUT_2(o2), .HOST_CLK(hclk));
    drxc_host host (.clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl(scl), .sda(sda));

    function automatic logic [14:0] fexp(input logic [2:0] c);
        return (c == 3'h7) ? 15'h6941 : 15'h6973 + {12'h000, c} * 15'h0032;
    endfunction

    // writes land only once the bus is idle again
    task automatic wr(input logic [7:0] d, output logic [1:0] a);
        logic [7:0] q;
        host.xfer(7'h6c, 1'b0, d, 1'b1, a, q);
        host.tick(4);
        @(negedge clk);
    endtask

    task automatic t_reset;
        `CHK("sleep", 1'b1, sleep)
        `CHK("code1", 3'h0, c1)
        `CHK("code2", 3'h0, c2)
        `CHK("freq1", 15'h6973, f1)
        `CHK("oe", 1'b1, sda_oe_n)
        $display("test reset done");
    endtask

    task automatic t_codes;
        logic [1:0] a;
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            wr({2'b00, ~k, k}, a);
            `CHK("ack", 2'b11, a)
            `CHK("sleep", 1'b0, sleep)
            `CHK("code1", k, c1)
            `CHK("code2", ~k, c2)
            `CHK("freq1", fexp(k), f1)
            `CHK("freq2", fexp(~k), f2)
        end
        $display("test codes done");
    endtask

    task automatic t_bad;
        logic [1:0] a;
        logic [7:0] q;
        host.xfer(7'h6d, 1'b0, 8'h80, 1'b1, a, q);
        host.tick(4);
        @(negedge clk);
        `CHK("nak", 1'b0, a[1])
        `CHK("sleep", 1'b0, sleep)
        `CHK("code1", 3'h7, c1)
        $display("test address done");
    endtask

    task automatic t_read;
        logic [1:0] a;
        logic [7:0] q;
        for (int i = 0; i < 16; i += 5) begin
            @(posedge clk);
            str1 <= 4'(i);
            str2 <= ~4'(i);
            host.xfer(7'h6c, 1'b1, 8'h00, 1'b1, a, q);
            `CHK("rack", 1'b1, a[1])
            `CHK("rbyte", {4'(i), ~4'(i)}, q)
        end
        $display("test read done");
    endtask

    // repeated starts keep the bus busy so the buffer cannot drain
    task automatic t_buf;
        logic [1:0] a;
        logic [7:0] q;
        host.xfer(7'h6c, 1'b0, 8'h01, 1'b0, a, q);
        `CHK("ack1", 2'b11, a)
        host.xfer(7'h6c, 1'b0, 8'h12, 1'b0, a, q);
        `CHK("ack2", 2'b11, a)
        host.xfer(7'h6c, 1'b0, 8'h23, 1'b1, a, q);
        `CHK("full", 2'b10, a)
        host.tick(4);
        @(negedge clk);
        `CHK("code1", 3'h2, c1)
        `CHK("code2", 3'h2, c2)
        $display("test buffer done");
    endtask

    task automatic t_sleep;
        logic [1:0] a;
        logic h;
        wr(8'h80, a);
        @(posedge clk);
        dm1 <= 1'b1;
        dm2 <= 1'b1;
        @(negedge clk);
        h = hclk;
        @(negedge clk);
        `CHK("sleep", 1'b1, sleep)
        `CHK("out1", 1'b0, o1)
        `CHK("out2", 1'b0, o2)
        `CHK("hclk", ~h, hclk)
        wr(8'h00, a);
        `CHK("out1", 1'b1, o1)
        @(posedge clk);
        dm1 <= 1'b0;
        @(negedge clk);
        `CHK("hold", 1'b1, o1)
        @(negedge clk);
        `CHK("out1", 1'b0, o1)
        `CHK("out2", 1'b1, o2)
        $display("test sleep done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        // settling wait scaled down to fit the run
        nrst <= 1'b1;
        @(negedge clk);
        t_reset();
        t_codes();
        t_bad();
        t_read();
        t_buf();
        t_sleep();
        print_verdict();
    end

    // about four times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict();
    end
endmodule // dual_receiver_i2c_control_tb_top
